// [irq_priority_low_power_ctrl.sv]
`timescale 1ns/100ps
module irq_priority_low_power_ctrl #(
  parameter int halt_delay = irq_lp_pkg::halt_delay_cycles,
  parameter bit wdog_in_wait = 1'b1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // cpu core events and mask
  input wire irq_lp_pkg::cpu_ev_t cpu_ev,
  input wire logic mask_set_req,
  input wire logic mask_clr_req,
  input wire logic slow_set_req,
  // option writes
  input wire logic opt_wr,
  input wire logic ext_irq_rise_sel_in,
  input wire logic ext_irq_fall_sel_in,
  input wire logic wdog_enabled,
  // pins and peripherals
  input wire logic ext_irq_pin,
  input wire logic [5:0] wakeup_port,
  input wire logic [3:0] timer_flag_set,
  input wire logic [3:0] timer_enable_reg,
  input wire irq_lp_pkg::tclr_t tclr,
  // outputs to cpu
  output logic irq_take,
  output logic [15:0] vec_addr,
  output logic stack_regs,
  output logic mask_bit,
  output logic slow_clock_bit,
  output logic ext_irq_rise_sel,
  output logic ext_irq_fall_sel,
  output logic [3:0] timer_flag_reg,
  output logic cpu_clk_en,
  output logic osc_en,
  output logic wdog_reset,
  output logic wdog_run
);
  initial begin
    if (halt_delay < 1 || halt_delay > 65535) $error("halt_delay out of range");
  end
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic ext_s1_q, ext_s2_q, ext_prev_q;
  logic [5:0] wk_s1_q, wk_s2_q;
  logic wk_prev_q, wk_any;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
      ext_prev_q <= 1'b1;
      wk_s1_q <= 6'h3f;
      wk_s2_q <= 6'h3f;
      wk_prev_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_irq_pin;
      ext_s2_q <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
      wk_s1_q <= wakeup_port;
      wk_s2_q <= wk_s1_q;
      wk_prev_q <= wk_any;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // trigger decode
  logic wk_edge, ext_fall, ext_rise, ext_edge, ext_level;
  assign wk_any = ~&wk_s2_q; // falling on any line raises the or
  assign wk_edge = wk_any & ~wk_prev_q;
  assign ext_fall = ext_prev_q & ~ext_s2_q;
  assign ext_rise = ~ext_prev_q & ext_s2_q;
  // both clear: fall plus low, fall only, rise only, both edges
  assign ext_edge = (ext_irq_fall_sel | ~ext_irq_rise_sel) & ext_fall |
                    ext_irq_rise_sel & ext_rise; // RULE1
  assign ext_level = ~ext_irq_rise_sel & ~ext_irq_fall_sel & ~ext_s2_q; // RULE1
  ////////////////////////////////////////////////////////////////////////
  // state and arbitration wires
  irq_lp_pkg::lp_state_t st_q, st_d;
  logic [15:0] cnt_q;
  logic ext_pend_q, wk_pend_q, rst_wake_q;
  logic [3:0] tlatch_q;
  logic [3:0] tclr_arm_q;
  logic opt_change, tim_icap, tim_ocmp, tim_tovf, ext_req, wk_req;
  logic grant_ok, take;
  logic [15:0] vec_d;
  logic [3:0] tclr_fire;
  assign opt_change = opt_wr & mask_bit & ((ext_irq_rise_sel_in != ext_irq_rise_sel) |
                      (ext_irq_fall_sel_in != ext_irq_fall_sel)); // RULE19
  assign tim_icap = tlatch_q[irq_lp_pkg::flag_icap] & timer_enable_reg[irq_lp_pkg::flag_icap];
  assign tim_ocmp = |(tlatch_q[2:1] & timer_enable_reg[2:1]); // RULE9
  assign tim_tovf = tlatch_q[irq_lp_pkg::flag_tovf] & timer_enable_reg[irq_lp_pkg::flag_tovf];
  assign ext_req = ext_pend_q | ext_level;
  assign wk_req = wk_pend_q;
  // boundary in run, or any wake in wait, or end of start-up delay after a halt wake
  assign grant_ok = (st_q == irq_lp_pkg::st_run) & cpu_ev.boundary |
                    (st_q == irq_lp_pkg::st_wait) |
                    (st_q == irq_lp_pkg::st_start) & (cnt_q == 16'h0001) & ~rst_wake_q; // RULE6
  // fixed priority, one grant per boundary
  always_comb begin
    take = 1'b0;
    vec_d = irq_lp_pkg::vec_reset;
    if (cpu_ev.trap_exec && st_q == irq_lp_pkg::st_run && cpu_ev.boundary) begin
      take = 1'b1; // RULE22
      vec_d = irq_lp_pkg::vec_trap; // RULE8
    end else if (grant_ok && !mask_bit) begin // RULE20
      take = ext_req | tim_icap | tim_ocmp | tim_tovf | wk_req; // RULE4 RULE23
      if (ext_req) vec_d = irq_lp_pkg::vec_ext; // RULE8
      else if (tim_icap) vec_d = irq_lp_pkg::vec_icap; // RULE9
      else if (tim_ocmp) vec_d = irq_lp_pkg::vec_ocmp;
      else if (tim_tovf) vec_d = irq_lp_pkg::vec_tovf;
      else vec_d = irq_lp_pkg::vec_wake; // RULE24
    end
  end
  // timer flag clear: status access arms, associated access clears
  assign tclr_fire = tclr_arm_q & tclr.assoc_access; // RULE7
  ////////////////////////////////////////////////////////////////////////
  // low power sequencing
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      irq_lp_pkg::st_run: begin
        if (cpu_ev.halt_exec && !wdog_enabled) st_d = irq_lp_pkg::st_halt; // RULE10 RULE11
        else if (cpu_ev.wait_exec) st_d = irq_lp_pkg::st_wait; // RULE15
      end
      irq_lp_pkg::st_wait: begin
        if (take) st_d = irq_lp_pkg::st_run; // RULE18
      end
      irq_lp_pkg::st_halt: begin
        if (ext_edge || ext_level || wk_edge) st_d = irq_lp_pkg::st_start; // RULE13
      end
      irq_lp_pkg::st_start: begin
        if (cnt_q == 16'h0001) st_d = irq_lp_pkg::st_run; // RULE14
      end
    endcase
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= irq_lp_pkg::st_start; // reset restarts through the delay
      cnt_q <= 16'(halt_delay);
      rst_wake_q <= 1'b1;
    end else begin
      st_q <= st_d;
      if (st_q == irq_lp_pkg::st_halt && st_d == irq_lp_pkg::st_start) begin
        cnt_q <= 16'(halt_delay); // RULE13
        rst_wake_q <= 1'b0;
      end else if (st_q == irq_lp_pkg::st_start && cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // pending latches
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ext_pend_q <= 1'b0;
      wk_pend_q <= 1'b0;
      tlatch_q <= 4'h0;
      tclr_arm_q <= 4'h0;
    end else begin
      // edge set wins over clear
      ext_pend_q <= ext_edge | (ext_pend_q & ~opt_change &
                    ~(take && vec_d == irq_lp_pkg::vec_ext)); // RULE19
      wk_pend_q <= wk_edge | (wk_pend_q & ~(take && vec_d == irq_lp_pkg::vec_wake)); // RULE2 RULE3
      tlatch_q <= timer_flag_set | (tlatch_q & ~tclr_fire); // RULE4 RULE7
      if (tclr.flag_reg_access) tclr_arm_q <= tlatch_q;
      else tclr_arm_q <= tclr_arm_q & ~tclr.assoc_access;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_take <= 1'b0;
      vec_addr <= irq_lp_pkg::vec_reset;
      stack_regs <= 1'b0;
      mask_bit <= 1'b1;
      slow_clock_bit <= 1'b0;
      ext_irq_rise_sel <= 1'b0;
      ext_irq_fall_sel <= 1'b0;
      timer_flag_reg <= 4'h0;
      cpu_clk_en <= 1'b0;
      osc_en <= 1'b1;
      wdog_reset <= 1'b0;
      wdog_run <= 1'b1;
    end else begin
      irq_take <= take;
      stack_regs <= take; // RULE21
      if (take) vec_addr <= vec_d;
      else if (st_q == irq_lp_pkg::st_start && rst_wake_q) vec_addr <= irq_lp_pkg::vec_reset;
      if (take) mask_bit <= 1'b1; // RULE21
      else if (st_d == irq_lp_pkg::st_halt || st_d == irq_lp_pkg::st_wait) begin
        mask_bit <= 1'b0; // RULE12 RULE17
      end else if (mask_clr_req) mask_bit <= 1'b0;
      else if (mask_set_req) mask_bit <= 1'b1;
      if (st_d == irq_lp_pkg::st_halt) slow_clock_bit <= 1'b0; // RULE12
      else if (slow_set_req) slow_clock_bit <= 1'b1;
      if (opt_wr && mask_bit) begin // RULE19
        ext_irq_rise_sel <= ext_irq_rise_sel_in;
        ext_irq_fall_sel <= ext_irq_fall_sel_in;
      end
      timer_flag_reg <= timer_flag_set | (tlatch_q & ~tclr_fire); // RULE5
      cpu_clk_en <= (st_d == irq_lp_pkg::st_run); // RULE15
      osc_en <= (st_d != irq_lp_pkg::st_halt); // RULE10
      wdog_reset <= cpu_ev.halt_exec & wdog_enabled & (st_q == irq_lp_pkg::st_run); // RULE11
      wdog_run <= (st_d == irq_lp_pkg::st_run) | (st_d == irq_lp_pkg::st_start) |
                  ((st_d == irq_lp_pkg::st_wait) & wdog_in_wait); // RULE16
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // checks
  trap_vector_a: assert property (@(posedge mclk) disable iff (!arst_n)
    cpu_ev.trap_exec && cpu_ev.boundary && st_q == irq_lp_pkg::st_run
    |=> irq_take && vec_addr == irq_lp_pkg::vec_trap) else $error("trap not granted"); // RULE22
  masked_grant_a: assert property (@(posedge mclk) disable iff (!arst_n)
    irq_take && vec_addr != irq_lp_pkg::vec_trap |-> !$past(mask_bit))
    else $error("masked grant"); // RULE20
  take_sets_mask_a: assert property (@(posedge mclk) disable iff (!arst_n)
    irq_take |-> mask_bit && stack_regs) else $error("mask not set"); // RULE21
  reserved_vec_a: assert property (@(posedge mclk) disable iff (!arst_n)
    vec_addr != irq_lp_pkg::vec_resvd) else $error("reserved vector"); // RULE24
  halt_entry_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_q == irq_lp_pkg::st_run && cpu_ev.halt_exec && !wdog_enabled
    |=> !mask_bit && !slow_clock_bit && !osc_en) else $error("halt entry"); // RULE12
  halt_wdog_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_q == irq_lp_pkg::st_run && cpu_ev.halt_exec && wdog_enabled
    |=> wdog_reset && st_q != irq_lp_pkg::st_halt) else $error("halt with watchdog"); // RULE11
  wait_entry_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_q == irq_lp_pkg::st_run && cpu_ev.wait_exec && !cpu_ev.halt_exec
    |=> !mask_bit && !cpu_clk_en && osc_en) else $error("wait entry"); // RULE17
  startup_delay_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_q == irq_lp_pkg::st_halt && st_d == irq_lp_pkg::st_start
    |=> cnt_q == 16'(halt_delay) && !cpu_clk_en) else $error("start-up delay"); // RULE13
  wake_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    wk_pend_q && mask_bit && !wk_edge |=> wk_pend_q) else $error("wake-up lost"); // RULE2
  // option write refused while the mask is clear
  opt_locked_a: assert property (@(posedge mclk) disable iff (!arst_n)
    opt_wr && !mask_bit |=> $stable(ext_irq_rise_sel) && $stable(ext_irq_fall_sel))
    else $error("option written with mask clear"); // RULE19
  // changed options drop a pending external request
  ext_discard_a: assert property (@(posedge mclk) disable iff (!arst_n)
    opt_change && !ext_edge |=> !ext_pend_q)
    else $error("pending ext kept over option change"); // RULE19
  // wake-up latch emptied by its own grant unless a new edge lands
  wake_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
    take && vec_d == irq_lp_pkg::vec_wake |=> !wk_pend_q || $past(wk_edge))
    else $error("wake-up latch not cleared"); // RULE3
  // halt holds with the oscillator off until a wake source
  halt_stay_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_q == irq_lp_pkg::st_halt && !(ext_edge || ext_level || wk_edge)
    |=> st_q == irq_lp_pkg::st_halt && !osc_en) else $error("halt left early"); // RULE13
  // cpu held off while the start-up count runs
  start_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_q == irq_lp_pkg::st_start && cnt_q > 16'h0001
    |=> !cpu_clk_en) else $error("cpu released during start-up"); // RULE13
  // cpu released at the end of the start-up count
  start_release_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_q == irq_lp_pkg::st_start && cnt_q == 16'h0001
    |=> cpu_clk_en && st_q == irq_lp_pkg::st_run) else $error("start-up not ended"); // RULE14
  // a grant in wait restarts the cpu with the vector
  wait_exit_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_q == irq_lp_pkg::st_wait && take
    |=> irq_take && cpu_clk_en) else $error("wait not left on grant"); // RULE18
  // with the mask set only the trap is granted
  mask_block_a: assert property (@(posedge mclk) disable iff (!arst_n)
    mask_bit && !cpu_ev.trap_exec |=> !irq_take)
    else $error("grant while masked"); // RULE20
  // no grant in run away from an instruction boundary
  boundary_only_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_q == irq_lp_pkg::st_run && !cpu_ev.boundary |=> !irq_take)
    else $error("grant off boundary"); // RULE6
  // watchdog in wait follows the build option
  wait_wdog_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_q == irq_lp_pkg::st_wait && st_d == irq_lp_pkg::st_wait
    |=> wdog_run == wdog_in_wait) else $error("watchdog wait option"); // RULE16
  // slow mode stays off through halt
  halt_slow_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_q == irq_lp_pkg::st_halt |-> !slow_clock_bit)
    else $error("slow mode in halt"); // RULE12
  // oscillator stopped for the whole halt
  halt_osc_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_q == irq_lp_pkg::st_halt |-> !osc_en)
    else $error("oscillator on in halt"); // RULE10
  // wait keeps the clock but stops the cpu
  wait_clock_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_q == irq_lp_pkg::st_wait |-> osc_en && !cpu_clk_en)
    else $error("wait clocking"); // RULE15
  // each armed clear drops its flag latch unless it is set again
  for (genvar gi = 0; gi < 4; gi++) begin : g_flag_chk
    flag_drop_a: assert property (@(posedge mclk) disable iff (!arst_n)
      tclr_fire[gi] && !timer_flag_set[gi] |=> !tlatch_q[gi])
      else $error("timer flag not cleared"); // RULE7
  end
endmodule // irq_priority_low_power_ctrl

// [irq_lp_pkg.sv]
// Overview of operation
// RULE1 - two select bits pick falling+low, falling, rising or both edges for ext pin
// RULE2 - wake-up port OR edge latched while mask set, held pending until mask clears
// RULE3 - wake-up latch holds one event, cleared at start of its service sequence
// RULE4 - timer flags interrupt only with mask clear and flag enable set, else pending
// RULE5 - timer flags live in status register 0013h, enables in control register 0012h
// RULE6 - enabled request taken only at instruction boundary, then service sequence starts
// RULE7 - status access with flag set then associated access clears flag and pending latch
// RULE8 - reset uses top vector pair, trap and external pin the next two below
// RULE9 - capture, compare, overflow each have own vector pair, descending, all maskable
// RULE10 - halt instruction stops oscillator and all internal processing
// RULE11 - halt with watchdog enabled issues watchdog reset instead
// RULE12 - entering halt clears mask bit and slow clock bit, nothing else changes
// RULE13 - halt exits on ext irq, wake-up or reset, then 4096-cycle start-up delay
// RULE14 - after halt delay service waking interrupt or fetch reset vector
// RULE15 - wait instruction stops cpu while clock and timer keep running
// RULE16 - watchdog active in wait according to build-time option
// RULE17 - entering wait clears mask bit, nothing else changes
// RULE18 - wait ends on any interrupt or reset, interrupt vectors then resumes
// RULE19 - trigger selects writable only with mask set, change discards pending ext irq
// RULE20 - priority trap, ext, capture, compare, overflow, wake-up; mask set allows trap only
// RULE21 - service pushes pc, index, acc, condition code then sets mask before vector load
// RULE22 - trap always recognised regardless of mask
// RULE23 - one highest-priority grant per instruction boundary among pending enabled
// RULE24 - pair below overflow reserved, never selected; wake-up uses lowest pair
package irq_lp_pkg;
  localparam logic [15:0] timer_enable_reg_addr = 16'h0012;
  localparam logic [15:0] timer_flag_reg_addr = 16'h0013;
  localparam logic [15:0] misc_reg_addr = 16'h000c;
  // vector low addresses
  localparam logic [15:0] vec_reset = 16'h1ffe;
  localparam logic [15:0] vec_trap = 16'h1ffc;
  localparam logic [15:0] vec_ext = 16'h1ffa;
  localparam logic [15:0] vec_icap = 16'h1ff8;
  localparam logic [15:0] vec_ocmp = 16'h1ff6;
  localparam logic [15:0] vec_tovf = 16'h1ff4;
  localparam logic [15:0] vec_resvd = 16'h1ff2;
  localparam logic [15:0] vec_wake = 16'h1ff0;
  // timer flag bit positions: capture, compare1, compare2, overflow
  localparam int flag_icap = 0;
  localparam int flag_ocmp1 = 1;
  localparam int flag_ocmp2 = 2;
  localparam int flag_tovf = 3;
  localparam int halt_delay_cycles = 4096;
  typedef enum logic [1:0] {
    st_run = 2'b00,
    st_wait = 2'b01,
    st_halt = 2'b11,
    st_start = 2'b10
  } lp_state_t;
  // cpu-side control strobes
  typedef struct packed {
    logic boundary;
    logic trap_exec;
    logic halt_exec;
    logic wait_exec;
    logic svc_start;
  } cpu_ev_t;
  // timer flag clear handshake
  typedef struct packed {
    logic flag_reg_access;
    logic [3:0] assoc_access;
  } tclr_t;
endpackage

// [periph_pin_model.sv]
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// pins and timer flag sources on the far side of the controller
module periph_pin_model (
  // clock
  input wire logic mclk,
  // pins and flag strobes
  output logic ext_irq_pin,
  output logic [5:0] wakeup_port,
  output logic [3:0] timer_flag_set
);
  // idle: pins pulled high, no strobes
  initial begin
    ext_irq_pin = 1'b1;
    wakeup_port = 6'h3f;
    timer_flag_set = 4'h0;
  end
  // low pulse on the external pin, long enough for the synchroniser
  task automatic ext_pulse();
    @(posedge mclk);
    #1 ext_irq_pin = 1'b0;
    repeat (4) @(posedge mclk);
    #1 ext_irq_pin = 1'b1;
  endtask
  // one port line pulled low then released to its pull-up
  task automatic wake_pulse(input int idx);
    @(posedge mclk);
    #1 wakeup_port[idx] = 1'b0;
    repeat (2) @(posedge mclk);
    #1 wakeup_port[idx] = 1'b1;
  endtask
  // one-cycle flag strobe from the timer
  task automatic flag_pulse(input int idx);
    @(posedge mclk);
    #1 timer_flag_set[idx] = 1'b1;
    @(posedge mclk);
    #1 timer_flag_set[idx] = 1'b0;
  endtask
endmodule // periph_pin_model

// [irq_priority_low_power_ctrl_tb_top.sv]
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module irq_priority_low_power_ctrl_tb_top;
  localparam int sim_delay = 8;
  localparam logic [15:0] vecs [5] = '{irq_lp_pkg::vec_ext, irq_lp_pkg::vec_icap,
    irq_lp_pkg::vec_ocmp, irq_lp_pkg::vec_tovf, irq_lp_pkg::vec_wake};
  localparam int fbit [5] = '{4, 0, 1, 3, 4};
  logic mclk, arst_n, mask_set_req, mask_clr_req, slow_set_req, opt_wr;
  logic ext_irq_rise_sel_in, ext_irq_fall_sel_in, wdog_enabled, ext_irq_pin;
  logic irq_take, stack_regs, mask_bit, slow_clock_bit, ext_irq_rise_sel, ext_irq_fall_sel;
  logic cpu_clk_en, osc_en, wdog_reset, wdog_run, s;
  logic [5:0] wakeup_port;
  logic [3:0] timer_flag_set, timer_enable_reg, timer_flag_reg;
  logic [15:0] vec_addr;
  irq_lp_pkg::cpu_ev_t cpu_ev;
  irq_lp_pkg::tclr_t tclr;
  int fails = 0;
  int num_checks = 0;
  int k;
  // design and far-side model
  irq_priority_low_power_ctrl #(.halt_delay(sim_delay), .wdog_in_wait(1'b1))
    i_irq_priority_low_power_ctrl (.mclk(mclk), .arst_n(arst_n), .cpu_ev(cpu_ev),
    .mask_set_req(mask_set_req), .mask_clr_req(mask_clr_req), .slow_set_req(slow_set_req),
    .opt_wr(opt_wr), .ext_irq_rise_sel_in(ext_irq_rise_sel_in),
    .ext_irq_fall_sel_in(ext_irq_fall_sel_in), .wdog_enabled(wdog_enabled),
    .ext_irq_pin(ext_irq_pin), .wakeup_port(wakeup_port), .timer_flag_set(timer_flag_set),
    .timer_enable_reg(timer_enable_reg), .tclr(tclr), .irq_take(irq_take),
    .vec_addr(vec_addr), .stack_regs(stack_regs), .mask_bit(mask_bit),
    .slow_clock_bit(slow_clock_bit), .ext_irq_rise_sel(ext_irq_rise_sel),
    .ext_irq_fall_sel(ext_irq_fall_sel), .timer_flag_reg(timer_flag_reg),
    .cpu_clk_en(cpu_clk_en), .osc_en(osc_en), .wdog_reset(wdog_reset), .wdog_run(wdog_run));
  periph_pin_model i_periph_pin_model (.mclk(mclk), .ext_irq_pin(ext_irq_pin),
    .wakeup_port(wakeup_port), .timer_flag_set(timer_flag_set));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // access tasks
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ev(input logic [4:0] v);
    cpu_ev = irq_lp_pkg::cpu_ev_t'(v);
    tick(1);
    cpu_ev = '0;
  endtask
  task automatic mreq(input logic [1:0] sc);
    mask_set_req = sc[1];
    mask_clr_req = sc[0];
    tick(1);
    mask_set_req = 1'b0;
    mask_clr_req = 1'b0;
  endtask
  task automatic lvl(input logic w, input logic [3:0] en);
    wdog_enabled = w;
    timer_enable_reg = en;
  endtask
  task automatic opt(input logic [1:0] c);
    ext_irq_rise_sel_in = c[1];
    ext_irq_fall_sel_in = c[0];
    opt_wr = ~opt_wr;
    tick(1);
    opt_wr = ~opt_wr;
    tick(1);
  endtask
  task automatic take(input logic [15:0] exp);
    for (int i = 0; i < 30 && irq_take !== 1'b1; i++) tick(1);
    chk({15'h0, irq_take}, 16'h1);
    chk(vec_addr, exp);
    chk({14'h0, stack_regs, mask_bit}, 16'h3);
  endtask
  task automatic no_take();
    s = 1'b0;
    repeat (4) begin
      s = s | irq_take;
      tick(1);
    end
    chk({15'h0, s}, 16'h0);
  endtask
  task automatic up_wait(input int min);
    int n;
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk({15'h0, cpu_clk_en}, 16'h1);
    chk({15'h0, n >= min}, 16'h1);
  endtask
  task automatic clear_flag(input int idx);
    tclr.flag_reg_access = 1'b1;
    tick(1);
    tclr = '0;
    tclr.assoc_access[idx] = 1'b1;
    tick(1);
    tclr = '0;
    tick(1);
    chk({15'h0, timer_flag_reg[idx]}, 16'h0);
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    {mask_set_req, mask_clr_req, slow_set_req, opt_wr, wdog_enabled} = 5'h0;
    {ext_irq_rise_sel_in, ext_irq_fall_sel_in} = 2'b00;
    cpu_ev = '0;
    tclr = '0;
    lvl(1'b0, 4'h0);
    arst_n = 1'b0;
    tick(2);
    chk({13'h0, mask_bit, osc_en, cpu_clk_en}, 16'h6);
    arst_n = 1'b1;
    up_wait(sim_delay - 1);
    chk(vec_addr, irq_lp_pkg::vec_reset);
    // pile up every source, then drain in priority order
    lvl(1'b0, 4'hf);
    i_periph_pin_model.flag_pulse(0);
    i_periph_pin_model.flag_pulse(1);
    i_periph_pin_model.flag_pulse(3);
    i_periph_pin_model.ext_pulse();
    i_periph_pin_model.wake_pulse(2);
    tick(5);
    chk({12'h0, timer_flag_reg}, 16'h000b);
    ev(5'b10000);
    no_take();
    ev(5'b11000);
    take(irq_lp_pkg::vec_trap);
    for (k = 0; k < 5; k++) begin
      mreq(2'b01);
      ev(5'b10000);
      take(vecs[k]);
      if (fbit[k] < 4) clear_flag(fbit[k]);
    end
    mreq(2'b01);
    ev(5'b10000);
    no_take();
    // pending but not enabled request is lost by the clear sequence
    lvl(1'b0, 4'h0);
    i_periph_pin_model.flag_pulse(2);
    ev(5'b10000);
    no_take();
    clear_flag(2);
    lvl(1'b0, 4'hf);
    ev(5'b10000);
    no_take();
    // trigger options: writable only with the mask set
    mreq(2'b10);
    for (k = 0; k < 4; k++) begin
      opt(k[1:0]);
      chk({14'h0, ext_irq_rise_sel, ext_irq_fall_sel}, k[15:0]);
    end
    mreq(2'b01);
    opt(2'b00);
    chk({14'h0, ext_irq_rise_sel, ext_irq_fall_sel}, 16'h3);
    // halt refused while the watchdog runs
    lvl(1'b1, 4'hf);
    ev(5'b00100);
    s = 1'b0;
    repeat (4) begin
      s = s | wdog_reset;
      tick(1);
    end
    chk({14'h0, s, cpu_clk_en & osc_en}, 16'h3);
    lvl(1'b0, 4'hf);
    // halt entry, port wake-up, start-up delay
    slow_set_req = ~slow_set_req;
    tick(1);
    slow_set_req = ~slow_set_req;
    mreq(2'b10);
    ev(5'b00100);
    tick(1);
    chk({13'h0, osc_en, mask_bit, slow_clock_bit}, 16'h0);
    i_periph_pin_model.wake_pulse(0);
    tick(3);
    chk({14'h0, osc_en, cpu_clk_en}, 16'h2);
    up_wait(1);
    take(irq_lp_pkg::vec_wake);
    // wait entry and timer wake
    ev(5'b00010);
    tick(1);
    chk({12'h0, cpu_clk_en, osc_en, mask_bit, wdog_run}, 16'h5);
    i_periph_pin_model.flag_pulse(3);
    take(irq_lp_pkg::vec_tovf);
    clear_flag(3);
    // both-edge mode: one pulse gives a falling and a rising request
    mreq(2'b01);
    i_periph_pin_model.ext_pulse();
    ev(5'b10000);
    take(irq_lp_pkg::vec_ext);
    mreq(2'b01);
    tick(3);
    ev(5'b10000);
    take(irq_lp_pkg::vec_ext);
    wrap_up();
  end
endmodule // irq_priority_low_power_ctrl_tb_top
